// file: hdl/apec_cfg.svh
`ifndef APEC_CFG_SVH
`define APEC_CFG_SVH

// register byte addresses on the axi4-lite port
`define APEC_OFF_CONFIG     8'h00
`define APEC_OFF_STATUS     8'h04
`define APEC_OFF_IRQ_STAT   8'h08
`define APEC_OFF_IRQ_MASK   8'h0c
`define APEC_OFF_PIN        8'h10

// field positions in the configuration and status words
`define APEC_BIT_PIN_DIS    15
`define APEC_BIT_READY      4
`define APEC_BIT_DOUBLE     1
`define APEC_BIT_SINGLE     0

// reset values
`define APEC_CONFIG_RST     16'hffff
`define APEC_STATUS_RST     16'hffff
`define APEC_MASK_RST       3'h0

// axi responses
`define APEC_RESP_OKAY      2'h0
`define APEC_RESP_SLVERR    2'h2

`endif

// file: hdl/apec_pkg.sv
package apec_pkg;

    // one-cycle internal event pulses
    typedef struct packed {
        logic ready;
        logic double_err;
        logic single_err;
    } apec_events_t;

    // write channel handshake phases
    typedef enum logic [1:0] {
        APEC_WR_IDLE = 2'b00,
        APEC_WR_RESP = 2'b01
    } apec_wr_state_t;

    // open-drain alert pin, enable is active low
    typedef struct packed {
        logic out;
        logic oe_n;
    } apec_pin_t;

endpackage

// file: hdl/apec_event_detect.sv
`timescale 1ns/1ps
`default_nettype none
module apec_event_detect
    import apec_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         ready_busy_n_i,
    input  wire logic         ecc_double_i,
    input  wire logic         ecc_single_i,
    output apec_events_t      events_o
);

    typedef struct packed {
        logic [2:0]   sync1;
        logic [2:0]   sync2;
        logic [2:0]   last;
        apec_events_t ev;
    } apec_det_state_t;

    apec_det_state_t s_q;
    apec_det_state_t s_d;

    // two-stage synchroniser, then edge detect on the second stage only
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = {ready_busy_n_i, ecc_double_i, ecc_single_i};
        s_d.sync2 = s_q.sync1;
        s_d.last  = s_q.sync2;
        s_d.ev.ready      = s_q.sync2[2] & ~s_q.last[2]; // busy to ready rise
        s_d.ev.double_err = s_q.sync2[1] & ~s_q.last[1];
        s_d.ev.single_err = s_q.sync2[0] & ~s_q.last[0];
    end

    // state register; ready line resets high so no false edge at start
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q <= '{sync1: 3'h4, sync2: 3'h4, last: 3'h4, ev: 3'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign events_o = s_q.ev;

endmodule
`default_nettype wire

// file: hdl/apec_alert_top.sv
// What this block does
// - The alert output is open drain and signals only that a selected internal event happened.
// - An enabled event drives the alert pin from high to low, and the config register picks the events.
// - Config bit 15 at zero enables the alert pin and at one disables it whatever the selects say.
// - Config bit 4 at zero lets a busy-to-ready transition pull the alert low, at one it is ignored.
// - Config bit 1 at zero lets a double-bit ecc detection pull the alert low, at one it is ignored.
// - Config bit 0 at zero lets a single-bit ecc correction pull the alert low, at one it is ignored.
// - A status register keeps active-low flags at bits 4, 1 and 0 for events since the host cleared it.
`timescale 1ns/1ps
`default_nettype none
`include "apec_cfg.svh"
module apec_alert_top
    import apec_pkg::*;
(
    input  wire logic         ref_clk_i,
    input  wire logic         arst_n_i,
    input  wire logic         ready_busy_n_i,
    input  wire logic         ecc_double_i,
    input  wire logic         ecc_single_i,
    input  wire logic         alert_n_i,
    output logic              alert_n_o,
    output logic              alert_n_oe_n_o,
    output logic              irq_o,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready
);

    typedef struct packed {
        logic [15:0]    config_r;
        logic [15:0]    status_r;
        logic [2:0]     irq_stat;
        logic [2:0]     irq_mask;
        logic [1:0]     pin_sync;
        apec_wr_state_t wr_st;
        logic           aw_have;
        logic           w_have;
        logic [7:0]     aw_addr;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
        apec_pin_t      pin;
        logic           irq;
        logic           aw_rdy;
        logic           w_rdy;
        logic           bvalid;
        logic           ar_rdy;
    } apec_state_t;

    apec_state_t  s_q;
    apec_state_t  s_d;
    apec_events_t ev;

    // synchronised edge pulses of the internal event lines
    apec_event_detect u_detect (
        .ref_clk_i      (ref_clk_i),
        .arst_n_i       (arst_n_i),
        .ready_busy_n_i (ready_busy_n_i),
        .ecc_double_i   (ecc_double_i),
        .ecc_single_i   (ecc_single_i),
        .events_o       (ev)
    );

    // merge a 16-bit register with a write under byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
        merge16 = old;
        if (st[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (st[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    // pick the three event bits out of their status layout positions
    function automatic logic [2:0] sel3(input logic [15:0] r);
        sel3 = {r[`APEC_BIT_READY], r[`APEC_BIT_DOUBLE], r[`APEC_BIT_SINGLE]};
    endfunction

    logic [2:0] ev_vec;
    logic [2:0] enabled_n;
    logic       wr_fire;
    logic       rd_fire;
    logic       pending;

    assign ev_vec = {ev.ready, ev.double_err, ev.single_err};

    always_comb begin
        s_d       = s_q;
        enabled_n = sel3(s_q.config_r);
        wr_fire   = 1'b0;
        rd_fire   = 1'b0;
        pending   = 1'b0;
        s_d.pin_sync = {s_q.pin_sync[0], alert_n_i};

        // write channel: address and data in either order, then response
        if (s_q.wr_st == APEC_WR_IDLE) begin
            if (s_axi_awvalid && !s_q.aw_have) begin
                s_d.aw_have = 1'b1;
                s_d.aw_addr = s_axi_awaddr;
            end
            if (s_axi_wvalid && !s_q.w_have) begin
                s_d.w_have = 1'b1;
                s_d.w_data = s_axi_wdata;
                s_d.w_strb = s_axi_wstrb;
            end
            if (s_d.aw_have && s_d.w_have) begin
                wr_fire   = 1'b1;
                s_d.wr_st = APEC_WR_RESP;
                s_d.aw_have = 1'b0;
                s_d.w_have  = 1'b0;
                s_d.bresp   = `APEC_RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            s_d.wr_st = APEC_WR_IDLE;
        end

        // register writes; writing a zero status bit back to one clears it
        if (wr_fire) begin
            case (s_d.aw_addr)
                `APEC_OFF_CONFIG: begin
                    s_d.config_r = merge16(s_q.config_r, s_d.w_data, s_d.w_strb);
                end
                `APEC_OFF_STATUS: begin
                    s_d.status_r = s_q.status_r | merge16(16'h0000, s_d.w_data, s_d.w_strb);
                end
                `APEC_OFF_IRQ_MASK: begin
                    if (s_d.w_strb[0]) begin
                        s_d.irq_mask = s_d.w_data[2:0];
                    end
                end
                `APEC_OFF_IRQ_STAT, `APEC_OFF_PIN: begin
                    s_d.bresp = `APEC_RESP_OKAY;
                end
                default: begin
                    s_d.bresp = `APEC_RESP_SLVERR;
                end
            endcase
        end

        // read channel, one beat held until rready
        if (s_q.rvalid) begin
            if (s_axi_rready) begin
                s_d.rvalid = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            rd_fire    = 1'b1;
            s_d.rvalid = 1'b1;
            s_d.rresp  = `APEC_RESP_OKAY;
            case (s_axi_araddr)
                `APEC_OFF_CONFIG:   s_d.rdata = {16'h0000, s_q.config_r};
                `APEC_OFF_STATUS:   s_d.rdata = {16'h0000, s_q.status_r};
                `APEC_OFF_IRQ_STAT: s_d.rdata = {29'h0, s_q.irq_stat};
                `APEC_OFF_IRQ_MASK: s_d.rdata = {29'h0, s_q.irq_mask};
                `APEC_OFF_PIN:      s_d.rdata = {30'h0, s_q.pin.oe_n, s_q.pin_sync[1]};
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = `APEC_RESP_SLVERR;
                end
            endcase
        end

        // sticky interrupt bits; read clears, new event wins
        if (rd_fire && s_axi_araddr == `APEC_OFF_IRQ_STAT) begin
            s_d.irq_stat = 3'h0;
        end
        s_d.irq_stat = s_d.irq_stat | ev_vec;

        // status flags go low on an event; an event beats a clear
        s_d.status_r[`APEC_BIT_READY]  = s_d.status_r[`APEC_BIT_READY] & ~ev.ready;
        s_d.status_r[`APEC_BIT_DOUBLE] = s_d.status_r[`APEC_BIT_DOUBLE] & ~ev.double_err;
        s_d.status_r[`APEC_BIT_SINGLE] = s_d.status_r[`APEC_BIT_SINGLE] & ~ev.single_err;

        // pin pulls low while an enabled flag is still set
        pending = |(~sel3(s_q.status_r) & ~enabled_n);
        if (s_q.config_r[`APEC_BIT_PIN_DIS]) begin
            pending = 1'b0;
        end
        s_d.pin.out  = 1'b0;
        s_d.pin.oe_n = ~pending;

        s_d.irq = |(s_d.irq_stat & s_q.irq_mask);

        // handshake outputs registered from the next state so each port is a flop
        s_d.aw_rdy = (s_d.wr_st == APEC_WR_IDLE) && !s_d.aw_have;
        s_d.w_rdy  = (s_d.wr_st == APEC_WR_IDLE) && !s_d.w_have;
        s_d.bvalid = (s_d.wr_st == APEC_WR_RESP);
        s_d.ar_rdy = !s_d.rvalid;
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q          <= '0;
            s_q.config_r <= `APEC_CONFIG_RST;
            s_q.status_r <= `APEC_STATUS_RST;
            s_q.irq_mask <= `APEC_MASK_RST;
            s_q.pin_sync <= 2'h3;
            s_q.pin.oe_n <= 1'b1;
            s_q.wr_st    <= APEC_WR_IDLE;
            s_q.aw_rdy   <= 1'b1;
            s_q.w_rdy    <= 1'b1;
            s_q.ar_rdy   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign alert_n_o      = s_q.pin.out;
    assign alert_n_oe_n_o = s_q.pin.oe_n;
    assign irq_o          = s_q.irq;
    assign s_axi_awready  = s_q.aw_rdy;
    assign s_axi_wready   = s_q.w_rdy;
    assign s_axi_bvalid   = s_q.bvalid;
    assign s_axi_bresp    = s_q.bresp;
    assign s_axi_arready  = s_q.ar_rdy;
    assign s_axi_rvalid   = s_q.rvalid;
    assign s_axi_rdata    = s_q.rdata;
    assign s_axi_rresp    = s_q.rresp;

endmodule
`default_nettype wire

// file: sim/apec_alert_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module apec_alert_asserts (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic ready_busy_n_i,
    input wire logic ecc_double_i,
    input wire logic ecc_single_i,
    input wire logic alert_n_o,
    input wire logic alert_n_oe_n_o,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [2:0] evt_w;
    logic [2:0] prev_q;
    logic [3:0] age_q;
    assign evt_w = {ready_busy_n_i, ecc_double_i, ecc_single_i};
    // cycles since the last rising event input or write response
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_q <= 3'h7;
            age_q  <= 4'hf;
        end else begin
            prev_q <= evt_w;
            if ((|(evt_w & ~prev_q)) || s_axi_bvalid) age_q <= 4'h0;
            else if (age_q != 4'hf) age_q <= age_q + 4'h1;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    od_drive_a: assert property (alert_n_o == 1'b0)
        else $error("alert driven high");
    fall_cause_a: assert property ($fell(alert_n_oe_n_o) |-> age_q <= 4'h8)
        else $error("alert fell without cause");
    pin_release_a: assert property ($rose(alert_n_oe_n_o) |->
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
        else $error("alert freed without write");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid stuck");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("rvalid dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready during response");
    r_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule
bind apec_alert_top apec_alert_asserts u_chk (
    .ref_clk_i      (ref_clk_i),
    .arst_n_i       (arst_n_i),
    .ready_busy_n_i (ready_busy_n_i),
    .ecc_double_i   (ecc_double_i),
    .ecc_single_i   (ecc_single_i),
    .alert_n_o      (alert_n_o),
    .alert_n_oe_n_o (alert_n_oe_n_o),
    .s_axi_bvalid   (s_axi_bvalid),
    .s_axi_bready   (s_axi_bready),
    .s_axi_arvalid  (s_axi_arvalid),
    .s_axi_arready  (s_axi_arready),
    .s_axi_rvalid   (s_axi_rvalid),
    .s_axi_rready   (s_axi_rready)
);
`default_nettype wire

// file: sim/apec_host_pin.sv
`timescale 1ns/1ps
`default_nettype none
module apec_host_pin (
    input  wire logic drv_i,
    input  wire logic oe_n_i,
    output logic      wire_n_o
);
    // host pull-up holds the line high once the device lets go
    assign wire_n_o = oe_n_i ? 1'b1 : drv_i;
endmodule
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "apec_cfg.svh"
module tb;
    logic        clk, arst_n, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv, drv, oe_n, irq, pin_n;
    logic [2:0]  evi, isb, mk;
    logic [7:0]  awa, ara, seed;
    logic [31:0] wd, rdat;
    logic [1:0]  br, rr;
    logic [15:0] cfg, st;
    int          mismatches, checks;
    apec_alert_top uut (.ref_clk_i(clk), .arst_n_i(arst_n), .ready_busy_n_i(evi[2]), .ecc_double_i(evi[1]),
        .ecc_single_i(evi[0]), .alert_n_i(pin_n), .alert_n_o(drv), .alert_n_oe_n_o(oe_n), .irq_o(irq),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre));
    apec_host_pin host (.drv_i(drv), .oe_n_i(oe_n), .wire_n_o(pin_n));
    // bench clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // write with bready held off for one cycle of the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `APEC_RESP_OKAY);
        int n = 0;
        {awa, wd, awv, wv} <= {a, d, 2'h3};
        while (1'b1) begin
            @(posedge clk);
            n++;
            if (bv === 1'b1 && bre === 1'b1) break;
            bre <= n > 1;
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end
        bre <= 1'b0;
        chk(br, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = `APEC_RESP_OKAY);
        int n = 0;
        {ara, arv} <= {a, 1'b1};
        while (1'b1) begin
            @(posedge clk);
            n++;
            if (rv === 1'b1 && rre === 1'b1) break;
            rre <= n > 1;
            if (arr) arv <= 1'b0;
        end
        rre <= 1'b0;
        chk(rdat, exp);
        chk(rr, er);
    endtask
    // pin level and interrupt against the model
    task automatic settle();
        logic exp_n;
        repeat (8) @(posedge clk);
        exp_n = cfg[15] || !(|(~st[4:0] & ~cfg[4:0] & 5'h13));
        chk(oe_n, exp_n);
        chk(pin_n, exp_n);
        chk(irq, |(isb & mk));
        rd(`APEC_OFF_PIN, {30'h0, exp_n, exp_n});
    endtask
    task automatic pulse(input int k);
        evi[k] <= 1'b0;
        repeat (3) @(posedge clk);
        evi[k] <= 1'b1;
        isb[k] = 1'b1;
        st[k == 2 ? 4 : k] = 1'b0;
        settle();
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {awv, wv, bre, arv, rre, evi, awa, ara, wd} = '0;
        {mismatches, checks} = '0;
        {cfg, st, isb, seed} = {32'hffffffff, 3'h0, 8'h07};
        arst_n = 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(`APEC_OFF_CONFIG, 32'hffff);
        rd(`APEC_OFF_STATUS, 32'hffff);
        rd(`APEC_OFF_IRQ_MASK, 32'h0);
        rd(8'h20, 32'h0, `APEC_RESP_SLVERR);
        wr(8'h20, 32'h0, `APEC_RESP_SLVERR);
        wr(`APEC_OFF_IRQ_STAT, 32'h7);
        rd(`APEC_OFF_IRQ_STAT, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            for (int s = 0; s < 2; s++) begin
                seed = lfsr(seed);
                mk = seed[2:0];
                wr(`APEC_OFF_IRQ_MASK, {29'h0, mk});
                cfg = 16'h7fff ^ (s ? 16'h1 << (k == 2 ? 4 : k) : 16'h0);
                wr(`APEC_OFF_CONFIG, {16'h0, cfg});
                pulse(k);
                cfg[15] = 1'b1;
                wr(`APEC_OFF_CONFIG, {16'h0, cfg});
                settle();
                cfg[15] = 1'b0;
                wr(`APEC_OFF_CONFIG, {16'h0, cfg});
                settle();
                rd(`APEC_OFF_CONFIG, {16'h0, cfg});
                rd(`APEC_OFF_STATUS, {16'h0, st});
                rd(`APEC_OFF_IRQ_STAT, {29'h0, isb});
                isb = 3'h0;
                rd(`APEC_OFF_IRQ_STAT, 32'h0);
                st = 16'hffff;
                wr(`APEC_OFF_STATUS, 32'hffff);
                settle();
                $display("test event %0d select %0d done", k, s);
            end
        end
        results();
    end
    // watchdog well beyond the expected run
    initial begin
        #200000;
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
